// [shared/chcal_pkg.sv]
package chcal_pkg;

	// ======================================================================
	// register bus
	// ======================================================================
	localparam int ADDR_W = 6;
	localparam int DATA_W = 16;

	// ======================================================================
	// register word addresses
	// ======================================================================
	localparam logic [5:0] ADDR_THR_HIGH  = 6'h07;
	localparam logic [5:0] ADDR_THR_LOW   = 6'h08;
	localparam logic [5:0] ADDR_CHANNEL0_CONFIG   = 6'h09;
	localparam logic [5:0] ADDR_OCAL_HIGH = 6'h0a;
	localparam logic [5:0] ADDR_OCAL_LOW  = 6'h0b;
	localparam logic [5:0] ADDR_GCAL_HIGH = 6'h0c;
	localparam logic [5:0] ADDR_GCAL_LOW  = 6'h0d;

	// ======================================================================
	// field positions
	// ======================================================================
	localparam int LOW_BYTE_LSB   = 8;
	localparam int LOW_BYTE_MSB   = 15;
	localparam int COEFF_LSB      = 0;
	localparam int COEFF_MSB      = 3;
	localparam int PHASE_LSB      = 6;
	localparam int PHASE_MSB      = 15;
	localparam int DC_OFF_BIT     = 2;
	localparam int MUX_LSB        = 0;
	localparam int MUX_MSB        = 1;

	// ======================================================================
	// writable masks and reset values
	// ======================================================================
	localparam logic [15:0] MASK_FULL     = 16'hffff;
	localparam logic [15:0] MASK_LOW_BYTE = 16'hff00;
	localparam logic [15:0] MASK_THR_LOW  = 16'hff0f;
	localparam logic [15:0] MASK_CHANNEL0_CONFIG  = 16'hffc7;
	localparam logic [15:0] RST_ZERO      = 16'h0000;
	localparam logic [15:0] RST_GCAL_HIGH = 16'h8000;

	// ======================================================================
	// enumerations
	// ======================================================================
	localparam logic [3:0] COEFF_OFF = 4'h0;

	typedef enum logic [1:0] {
		CHCAL_IN_PINS    = 2'h0,
		CHCAL_IN_SHORT   = 2'h1,
		CHCAL_IN_TEST_P  = 2'h2,
		CHCAL_IN_TEST_N  = 2'h3
	} chcal_input_e;

endpackage

// [src/chcal_word_reg.sv]
`timescale 1ns/100ps
// one register word; bits outside the mask never leave their reset value
module chcal_word_reg #(
	parameter logic [15:0] RESET_VAL = 16'h0000,
	parameter logic [15:0] WR_MASK   = 16'hffff
) (
	// clock and reset
	input  wire logic        mclk_in,
	input  wire logic        resetn_in,
	// write port
	input  wire logic        wr_in,
	input  wire logic [15:0] wdata_in,
	// stored value
	output logic      [15:0] value_out
);

	logic [15:0] next_value;

	always_comb begin
		next_value = value_out;
		if (wr_in) begin
			next_value = (wdata_in & WR_MASK) | (RESET_VAL & ~WR_MASK);
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!resetn_in) begin
			value_out <= RESET_VAL;
		end else begin
			value_out <= next_value;
		end
	end

endmodule

// [src/chcal_rdmux.sv]
`timescale 1ns/100ps
// registered read path: data stand only in the cycle after the read strobe
module chcal_rdmux (
	// clock and reset
	input  wire logic        mclk_in,
	input  wire logic        resetn_in,
	// request
	input  wire logic        rd_in,
	input  wire logic [5:0]  addr_in,
	// register contents
	input  wire logic [15:0] thr_high_in,
	input  wire logic [15:0] thr_low_in,
	input  wire logic [15:0] cfg_in,
	input  wire logic [15:0] ocal_high_in,
	input  wire logic [15:0] ocal_low_in,
	input  wire logic [15:0] gcal_high_in,
	input  wire logic [15:0] gcal_low_in,
	// answer
	output logic      [15:0] rdata_out
);

	logic [15:0] next_rdata;

	always_comb begin
		next_rdata = 16'h0000;
		if (rd_in) begin
			case (addr_in)
				chcal_pkg::ADDR_THR_HIGH:  next_rdata = thr_high_in;
				chcal_pkg::ADDR_THR_LOW:   next_rdata = thr_low_in;
				chcal_pkg::ADDR_CHANNEL0_CONFIG:   next_rdata = cfg_in;
				chcal_pkg::ADDR_OCAL_HIGH: next_rdata = ocal_high_in;
				chcal_pkg::ADDR_OCAL_LOW:  next_rdata = ocal_low_in;
				chcal_pkg::ADDR_GCAL_HIGH: next_rdata = gcal_high_in;
				chcal_pkg::ADDR_GCAL_LOW:  next_rdata = gcal_low_in;
				// unmapped addresses answer zero
				default:                   next_rdata = 16'h0000;
			endcase
		end
	end

	always_ff @(posedge mclk_in) begin
		if (!resetn_in) begin
			rdata_out <= 16'h0000;
		end else begin
			rdata_out <= next_rdata;
		end
	end

endmodule

// [src/chcal_regs.sv]
// The address-and-strobe port was decided locally.
`timescale 1ns/100ps
// ==========================================================================
// channel 0 configuration and calibration register bank
// ==========================================================================
// Contract
// - the upper sixteen threshold bits live in a full read-write word that resets to zero.
// - the threshold low byte sits in bits 15:8 of the next word, read-write, reset zero.
// - bits 3:0 pick the dc-removal coefficient, zero meaning off, reset zero.
// - channel 0 config bits 15:6 hold a signed ten-bit phase delay, reset zero.
// - config bit 2 set turns dc removal off for channel 0 alone, reset zero.
// - config bits 1:0 pick the input: pins, shorted, positive or negative test.
// - offset correction bits 23:8 sit in a full read-write word, reset zero.
// - offset correction bits 7:0 sit in bits 15:8 of the next word, reset zero.
// - gain correction bits 23:8 sit in a read-write word that resets to 8000h.
// - gain correction bits 7:0 sit in bits 15:8 of the next word, reset zero.
module chcal_regs (
	// clock and reset
	input  wire logic        mclk_in,
	input  wire logic        resetn_in,
	// register port
	input  wire logic [5:0]  addr_in,
	input  wire logic [15:0] wdata_in,
	input  wire logic        wr_in,
	input  wire logic        rd_in,
	output logic      [15:0] rdata_out,
	// threshold to the current-detect logic
	output logic      [23:0] cur_detect_limit_out,
	// dc removal to the filter
	output logic      [3:0]  dc_removal_coeff_sel_out,
	output logic             ch0_dc_removal_en_out,
	output logic      [3:0]  ch0_dc_removal_coeff_out,
	// channel 0 datapath controls
	output logic      [9:0]  ch0_phase_delay_out,
	output logic      [1:0]  ch0_input_select_out,
	output logic             ch0_use_pins_out,
	output logic      [23:0] ch0_offset_corr_out,
	output logic      [23:0] ch0_gain_corr_out
);

	// ======================================================================
	// write decode
	// ======================================================================
	logic        wr_thr_high;
	logic        wr_thr_low;
	logic        wr_cfg;
	logic        wr_ocal_high;
	logic        wr_ocal_low;
	logic        wr_gcal_high;
	logic        wr_gcal_low;

	assign wr_thr_high  = wr_in && (addr_in == chcal_pkg::ADDR_THR_HIGH);
	assign wr_thr_low   = wr_in && (addr_in == chcal_pkg::ADDR_THR_LOW);
	assign wr_cfg       = wr_in && (addr_in == chcal_pkg::ADDR_CHANNEL0_CONFIG);
	assign wr_ocal_high = wr_in && (addr_in == chcal_pkg::ADDR_OCAL_HIGH);
	assign wr_ocal_low  = wr_in && (addr_in == chcal_pkg::ADDR_OCAL_LOW);
	assign wr_gcal_high = wr_in && (addr_in == chcal_pkg::ADDR_GCAL_HIGH);
	assign wr_gcal_low  = wr_in && (addr_in == chcal_pkg::ADDR_GCAL_LOW);

	// ======================================================================
	// register words
	// ======================================================================
	logic [15:0] thr_high;
	logic [15:0] thr_low;
	logic [15:0] cfg;
	logic [15:0] ocal_high;
	logic [15:0] ocal_low;
	logic [15:0] gcal_high;
	logic [15:0] gcal_low;

	chcal_word_reg #(
		.RESET_VAL (chcal_pkg::RST_ZERO),
		.WR_MASK   (chcal_pkg::MASK_FULL)
	) u_thr_high (
		.mclk_in   (mclk_in),
		.resetn_in (resetn_in),
		.wr_in     (wr_thr_high),
		.wdata_in  (wdata_in),
		.value_out (thr_high)
	);

	// bits 7:4 masked off so they read zero
	chcal_word_reg #(
		.RESET_VAL (chcal_pkg::RST_ZERO),
		.WR_MASK   (chcal_pkg::MASK_THR_LOW)
	) u_thr_low (
		.mclk_in   (mclk_in),
		.resetn_in (resetn_in),
		.wr_in     (wr_thr_low),
		.wdata_in  (wdata_in),
		.value_out (thr_low)
	);

	// bits 5:3 reserved
	chcal_word_reg #(
		.RESET_VAL (chcal_pkg::RST_ZERO),
		.WR_MASK   (chcal_pkg::MASK_CHANNEL0_CONFIG)
	) u_cfg (
		.mclk_in   (mclk_in),
		.resetn_in (resetn_in),
		.wr_in     (wr_cfg),
		.wdata_in  (wdata_in),
		.value_out (cfg)
	);

	chcal_word_reg #(
		.RESET_VAL (chcal_pkg::RST_ZERO),
		.WR_MASK   (chcal_pkg::MASK_FULL)
	) u_ocal_high (
		.mclk_in   (mclk_in),
		.resetn_in (resetn_in),
		.wr_in     (wr_ocal_high),
		.wdata_in  (wdata_in),
		.value_out (ocal_high)
	);

	chcal_word_reg #(
		.RESET_VAL (chcal_pkg::RST_ZERO),
		.WR_MASK   (chcal_pkg::MASK_LOW_BYTE)
	) u_ocal_low (
		.mclk_in   (mclk_in),
		.resetn_in (resetn_in),
		.wr_in     (wr_ocal_low),
		.wdata_in  (wdata_in),
		.value_out (ocal_low)
	);

	// unity gain after reset
	chcal_word_reg #(
		.RESET_VAL (chcal_pkg::RST_GCAL_HIGH),
		.WR_MASK   (chcal_pkg::MASK_FULL)
	) u_gcal_high (
		.mclk_in   (mclk_in),
		.resetn_in (resetn_in),
		.wr_in     (wr_gcal_high),
		.wdata_in  (wdata_in),
		.value_out (gcal_high)
	);

	chcal_word_reg #(
		.RESET_VAL (chcal_pkg::RST_ZERO),
		.WR_MASK   (chcal_pkg::MASK_LOW_BYTE)
	) u_gcal_low (
		.mclk_in   (mclk_in),
		.resetn_in (resetn_in),
		.wr_in     (wr_gcal_low),
		.wdata_in  (wdata_in),
		.value_out (gcal_low)
	);

	// ======================================================================
	// read path
	// ======================================================================
	chcal_rdmux u_rdmux (
		.mclk_in      (mclk_in),
		.resetn_in    (resetn_in),
		.rd_in        (rd_in),
		.addr_in      (addr_in),
		.thr_high_in  (thr_high),
		.thr_low_in   (thr_low),
		.cfg_in       (cfg),
		.ocal_high_in (ocal_high),
		.ocal_low_in  (ocal_low),
		.gcal_high_in (gcal_high),
		.gcal_low_in  (gcal_low),
		.rdata_out    (rdata_out)
	);

	// ======================================================================
	// datapath controls
	// ======================================================================
	// registered so each output leaves a flip-flop; they trail the word
	// registers by one cycle, which the slow datapath never notices
	logic [23:0] next_limit;
	logic [3:0]  next_coeff_sel;
	logic        next_dc_en;
	logic [3:0]  next_dc_coeff;
	logic [9:0]  next_phase;
	logic [1:0]  next_input_sel;
	logic        next_use_pins;
	logic [23:0] next_ocal;
	logic [23:0] next_gcal;

	always_comb begin
		next_limit = {thr_high,
			thr_low[chcal_pkg::LOW_BYTE_MSB:chcal_pkg::LOW_BYTE_LSB]};
		next_coeff_sel =
			thr_low[chcal_pkg::COEFF_MSB:chcal_pkg::COEFF_LSB];
		// override forces the filter off for this channel only
		next_dc_en = (next_coeff_sel != chcal_pkg::COEFF_OFF)
			&& !cfg[chcal_pkg::DC_OFF_BIT];
		next_dc_coeff = next_dc_en ? next_coeff_sel
			: chcal_pkg::COEFF_OFF;
		next_phase = cfg[chcal_pkg::PHASE_MSB:chcal_pkg::PHASE_LSB];
		next_input_sel = cfg[chcal_pkg::MUX_MSB:chcal_pkg::MUX_LSB];
		next_use_pins = (next_input_sel
			== chcal_pkg::CHCAL_IN_PINS);
		next_ocal = {ocal_high,
			ocal_low[chcal_pkg::LOW_BYTE_MSB:chcal_pkg::LOW_BYTE_LSB]};
		next_gcal = {gcal_high,
			gcal_low[chcal_pkg::LOW_BYTE_MSB:chcal_pkg::LOW_BYTE_LSB]};
	end

	always_ff @(posedge mclk_in) begin
		if (!resetn_in) begin
			cur_detect_limit_out     <= 24'h000000;
			dc_removal_coeff_sel_out <= chcal_pkg::COEFF_OFF;
			ch0_dc_removal_en_out    <= 1'b0;
			ch0_dc_removal_coeff_out <= chcal_pkg::COEFF_OFF;
			ch0_phase_delay_out      <= 10'h000;
			ch0_input_select_out     <= chcal_pkg::CHCAL_IN_PINS;
			ch0_use_pins_out         <= 1'b1;
			ch0_offset_corr_out      <= 24'h000000;
			ch0_gain_corr_out        <= {chcal_pkg::RST_GCAL_HIGH, 8'h00};
		end else begin
			cur_detect_limit_out     <= next_limit;
			dc_removal_coeff_sel_out <= next_coeff_sel;
			ch0_dc_removal_en_out    <= next_dc_en;
			ch0_dc_removal_coeff_out <= next_dc_coeff;
			ch0_phase_delay_out      <= next_phase;
			ch0_input_select_out     <= next_input_sel;
			ch0_use_pins_out         <= next_use_pins;
			ch0_offset_corr_out      <= next_ocal;
			ch0_gain_corr_out        <= next_gcal;
		end
	end

endmodule

// [tb/chcal_regs_monitor.sv]
`timescale 1ns/100ps
// ==========
// port checker
// ==========
module chcal_regs_monitor (
	// bus side
	input wire logic        mclk_in,
	input wire logic        resetn_in,
	input wire logic [5:0]  addr_in,
	input wire logic [15:0] wdata_in,
	input wire logic        wr_in,
	input wire logic        rd_in,
	input wire logic [15:0] rdata_out,
	// datapath side
	input wire logic [23:0] cur_detect_limit_out,
	input wire logic [3:0]  dc_removal_coeff_sel_out,
	input wire logic        ch0_dc_removal_en_out,
	input wire logic [3:0]  ch0_dc_removal_coeff_out,
	input wire logic [9:0]  ch0_phase_delay_out,
	input wire logic [1:0]  ch0_input_select_out,
	input wire logic [23:0] ch0_offset_corr_out,
	input wire logic [23:0] ch0_gain_corr_out
);
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (!resetn_in);
	// datapath lags the word by one edge, hence the depth of two
	property p_idle;
		!rd_in || addr_in < 6'h07 || addr_in > 6'h0d |=> rdata_out == 16'h0;
	endproperty
	a_idle: assert property (p_idle)
		else $error("read data outside a mapped read");
	property p_lo;
		wr_in && addr_in == 6'h08 |=> ##1
			cur_detect_limit_out[7:0] == 8'($past(wdata_in, 2) >> 8);
	endproperty
	a_lo: assert property (p_lo)
		else $error("threshold low byte");
	property p_coeff;
		wr_in && addr_in == 6'h08 |=> ##1
			dc_removal_coeff_sel_out == 4'($past(wdata_in, 2));
	endproperty
	a_coeff: assert property (p_coeff)
		else $error("coefficient code");
	property p_cfg;
		wr_in && addr_in == 6'h09 |=> ##1
			{ch0_phase_delay_out, 4'h0, ch0_input_select_out} ==
			($past(wdata_in, 2) & 16'hffc3);
	endproperty
	a_cfg: assert property (p_cfg)
		else $error("phase or input select");
	property p_dc;
		wr_in && addr_in == 6'h09 && wdata_in[2] |=> ##1
			!ch0_dc_removal_en_out && ch0_dc_removal_coeff_out == 4'h0;
	endproperty
	a_dc: assert property (p_dc)
		else $error("channel dc removal not off");
	property p_ocal;
		wr_in && addr_in == 6'h0a |=> ##1
			ch0_offset_corr_out[23:8] == $past(wdata_in, 2);
	endproperty
	a_ocal: assert property (p_ocal)
		else $error("offset upper word");
	property p_gcal;
		wr_in && addr_in == 6'h0d |=> ##1
			ch0_gain_corr_out[7:0] == 8'($past(wdata_in, 2) >> 8);
	endproperty
	a_gcal: assert property (p_gcal)
		else $error("gain low byte");
	property p_resv;
		rd_in && addr_in == 6'h0b |=> rdata_out[7:0] == 8'h00;
	endproperty
	a_resv: assert property (p_resv)
		else $error("reserved bits not zero");
	property p_rst;
		$rose(resetn_in) |->
			ch0_gain_corr_out == 24'h800000 && cur_detect_limit_out == 24'h0;
	endproperty
	a_rst: assert property (p_rst)
		else $error("reset values");
	c_cfg: cover property (wr_in && addr_in == 6'h09 && wdata_in[2]);
	c_resv: cover property (rd_in && addr_in == 6'h0b);
	c_dc_on: cover property (ch0_dc_removal_en_out);
endmodule

// [tb/chcal_regs_tb.sv]
`timescale 1ns/100ps
// ==========
// register bank bench
// ==========
module chcal_regs_tb;
	logic        mclk_in   = 1'b0;
	logic        resetn_in = 1'b0;
	logic [5:0]  addr_in   = 6'h00;
	logic [15:0] wdata_in  = 16'h0000;
	logic        wr_in     = 1'b0;
	logic        rd_in     = 1'b0;
	logic [15:0] rdata_out;
	logic [23:0] lim;
	logic [23:0] ocal;
	logic [23:0] gcal;
	logic [3:0]  sel;
	logic [3:0]  coef;
	logic [9:0]  phase;
	logic [1:0]  isel;
	logic        den;
	logic        pins;
	int          bad_count = 0;
	int          checks    = 0;
	// reset values and read-back masks of words 07h to 0dh
	logic [15:0] rst_v [7] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000,
		16'h0000, 16'h8000, 16'h0000};
	logic [15:0] mask_v [7] = '{16'hffff, 16'hff0f, 16'hffc7, 16'hffff,
		16'hff00, 16'hffff, 16'hff00};
	chcal_regs i_dut (
		.mclk_in, .resetn_in, .addr_in, .wdata_in, .wr_in, .rd_in,
		.rdata_out,
		.cur_detect_limit_out     (lim),
		.dc_removal_coeff_sel_out (sel),
		.ch0_dc_removal_en_out    (den),
		.ch0_dc_removal_coeff_out (coef),
		.ch0_phase_delay_out      (phase),
		.ch0_input_select_out     (isel),
		.ch0_use_pins_out         (pins),
		.ch0_offset_corr_out      (ocal),
		.ch0_gain_corr_out        (gcal)
	);
	always #4 mclk_in = ~mclk_in;
	task automatic complete_run();
		$display("checks %0d bad_count %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic chk(string n, logic [23:0] e, logic [23:0] g);
		checks++;
		if (g !== e) begin
			bad_count++;
			$display("Error %s expected %h seen %h", n, e, g);
		end
	endtask
	// strobe drops at the sampling edge, so calls may follow with no gap
	task automatic wr(logic [5:0] a, logic [15:0] d);
		wr_in    <= 1'b1;
		addr_in  <= a;
		wdata_in <= d;
		@(posedge mclk_in);
		wr_in <= 1'b0;
		#1;
	endtask
	task automatic rd(logic [5:0] a, logic [15:0] e);
		rd_in   <= 1'b1;
		addr_in <= a;
		@(posedge mclk_in);
		rd_in <= 1'b0;
		#1 chk($sformatf("word %h", a), 24'(e), 24'(rdata_out));
	endtask
	task automatic idle();
		@(posedge mclk_in);
		#1;
	endtask
	task automatic t_reset();
		for (int i = 0; i < 7; i++)
			rd(6'h07 + 6'(i), rst_v[i]);
		rd(6'h3f, 16'h0000);
		chk("gain", 24'h800000, gcal);
		chk("pins", 24'h1, 24'(pins));
		chk("limit", 24'h0, lim);
	endtask
	task automatic t_mask();
		for (int i = 0; i < 7; i++) begin
			wr(6'h07 + 6'(i), 16'hffff);
			rd(6'h07 + 6'(i), mask_v[i]);
		end
		idle();
		chk("limit", 24'hffffff, lim);
		chk("offset", 24'hffffff, ocal);
		chk("gain", 24'hffffff, gcal);
		chk("phase", 24'h3ff, 24'(phase));
		chk("dc on", 24'h0, 24'(den));
		wr(6'h0e, 16'h1234);
		wr(6'h06, 16'h1234);
		rd(6'h0e, 16'h0000);
		rd(6'h07, 16'hffff);
	endtask
	task automatic t_join();
		wr(6'h07, 16'h9876);
		wr(6'h08, 16'h5400);
		wr(6'h0a, 16'h1234);
		wr(6'h0b, 16'h56ff);
		wr(6'h0c, 16'habcd);
		wr(6'h0d, 16'hef00);
		idle();
		chk("limit", 24'h987654, lim);
		chk("offset", 24'h123456, ocal);
		chk("gain", 24'habcdef, gcal);
		rd(6'h0b, 16'h5600);
	endtask
	task automatic t_cfg();
		for (int i = 0; i < 4; i++) begin
			wr(6'h09, {10'h200, 4'h0, 2'(i)});
			idle();
			chk("input", 24'(i), 24'(isel));
			chk("pins", 24'(i == 0), 24'(pins));
			chk("phase", 24'h200, 24'(phase));
		end
	endtask
	task automatic t_coeff();
		for (int c = 0; c < 16; c++) begin
			wr(6'h08, {12'h000, 4'(c)});
			idle();
			chk("coeff", 24'(c), 24'(sel));
			chk("dc on", 24'(c != 0), 24'(den));
			chk("ch0 code", 24'(c), 24'(coef));
		end
		wr(6'h09, 16'h0004);
		idle();
		chk("dc on", 24'h0, 24'(den));
		chk("ch0 code", 24'h0, 24'(coef));
	endtask
	// reset in mid-run must throw away what software wrote
	task automatic t_again();
		wr(6'h0c, 16'h1234);
		wr(6'h07, 16'h5678);
		resetn_in <= 1'b0;
		idle();
		resetn_in <= 1'b1;
		idle();
		rd(6'h0c, 16'h8000);
		rd(6'h07, 16'h0000);
		chk("gain", 24'h800000, gcal);
		chk("limit", 24'h0, lim);
	endtask
	initial begin
		repeat (3) @(posedge mclk_in);
		resetn_in <= 1'b1;
		idle();
		t_reset();
		t_mask();
		t_join();
		t_cfg();
		t_coeff();
		t_again();
		complete_run();
	end
	// whole run is under a hundred cycles; this is over twenty times that
	initial begin
		#20000;
		bad_count++;
		complete_run();
	end
endmodule
bind chcal_regs chcal_regs_monitor i_mon (
	.mclk_in, .resetn_in, .addr_in, .wdata_in, .wr_in, .rd_in,
	.rdata_out, .cur_detect_limit_out, .dc_removal_coeff_sel_out,
	.ch0_dc_removal_en_out, .ch0_dc_removal_coeff_out,
	.ch0_phase_delay_out, .ch0_input_select_out,
	.ch0_offset_corr_out, .ch0_gain_corr_out
);
